// file: hw/lss_status_regs.sv
// Contract
// R1 - General status bit 6 shows the far-end receiver lock.
// R2 - Bit 4 sets on any change of back-channel link presence.
// R3 - Bit 4 clears on error-clear register read or forward PLL unlock.
// R4 - Bit 3 sets on self-test back-channel error; errors counted separately.
// R5 - Bit 2 shows forward PLL lock, reset value 1.
// R6 - Bit 1 sets on back-channel errors only while link present.
// R7 - Bit 1 holds until error-clear read; status read leaves it.
// R8 - Bit 0 high while back-channel link valid, reset value 1.
// R9 - Pin register bits 3:0 show live pin levels; 7:4 read zero.
// R10 - Register 0x54 counts self-test check errors, resets to 0.
// R11 - 16-bit check error count at 0x55 low, 0x56 high, reset 0.
// R12 - Alarm bits 5 and 4: temperature over and under, clear on read.
// R13 - Alarm bits 3 and 2: pin-1 voltage over and under, clear on read.
// R14 - Alarm bits 1 and 0: pin-0 voltage over and under, clear on read.
// R15 - Pin-0 bits 6:4 catch peak reading while over; read clears to 0.
// R16 - Pin-0 bits 2:0 catch trough reading while under; read sets 7.
// R17 - A set event in a clearing cycle keeps the bit set.
// R18 - Counters saturate at all ones; reserved bits read zero.
`timescale 1ns/1ps
module lss_status_regs #(
  parameter int ADDR_W = 10
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire lss_pkg::lss_link_t LINK_IN,
  input wire logic [3:0] PIN_LEVELS,
  input wire lss_pkg::lss_sense_t [2:0] SENSE,
  output logic IRQ
);

  // Bus slave state
  lss_pkg::lss_state_t state_q;
  lss_pkg::lss_state_t state_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Sampled link and pin state
  logic remote_lock_q;
  logic backlink_q;
  logic pll_q;
  logic [3:0] pins_q;

  // Sticky flags and counters
  logic link_lost_q;
  logic link_lost_d;
  logic check_err_q;
  logic check_err_d;
  logic selftest_err_q;
  logic selftest_err_d;
  logic [7:0] selftest_cnt_q;
  logic [7:0] selftest_cnt_d;
  logic [15:0] check_cnt_q;
  logic [15:0] check_cnt_d;

  // Interrupts
  logic [3:0] irq_st_q;
  logic [3:0] irq_st_d;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_mask_d;
  logic [3:0] irq_ev;
  logic irq_q;

  // Decode
  logic [7:0] idx;
  logic aligned;
  logic hit;
  logic access;
  logic rd_take;
  logic wr_take;
  logic err_clear_rd;
  logic alarm_rd;
  logic ext_rd;
  logic irq_rd;
  logic mask_wr;
  logic [31:0] rd_word;

  // Events
  logic link_change;
  logic pll_lost;
  logic check_ev;
  logic selftest_ev;
  logic [7:0] general_word;
  logic [5:0] alarm_bits;
  logic [2:0] ch_over;
  logic [2:0] ch_under;
  logic [2:0] ch_live;
  logic [2:0] ch_peak [3];
  logic [2:0] ch_trough [3];

  assign idx = PADDR[9:2];
  assign aligned = PADDR[1:0] == 2'h0;
  assign hit = aligned && (idx == lss_pkg::IDX_GENERAL || idx == lss_pkg::IDX_PINS
             || idx == lss_pkg::IDX_SELFTEST_CNT || idx == lss_pkg::IDX_CHECK_LO
             || idx == lss_pkg::IDX_CHECK_HI || idx == lss_pkg::IDX_ALARM
             || idx == lss_pkg::IDX_PIN0_EXT || idx == lss_pkg::IDX_ERR_CLEAR
             || idx == lss_pkg::IDX_IRQ_STATUS || idx == lss_pkg::IDX_IRQ_MASK);

  // Side effects fire once, at the edge the answer is latched
  assign access = (state_q == lss_pkg::LSS_ST_WAIT) && PSEL && PENABLE;
  assign rd_take = access && !PWRITE && hit;
  assign wr_take = access && PWRITE && hit;
  assign err_clear_rd = rd_take && idx == lss_pkg::IDX_ERR_CLEAR;
  assign alarm_rd = rd_take && idx == lss_pkg::IDX_ALARM;
  assign ext_rd = rd_take && idx == lss_pkg::IDX_PIN0_EXT;
  assign irq_rd = rd_take && idx == lss_pkg::IDX_IRQ_STATUS;
  assign mask_wr = wr_take && idx == lss_pkg::IDX_IRQ_MASK;

  assign state_d = (state_q == lss_pkg::LSS_ST_WAIT)
                 ? (access ? lss_pkg::LSS_ST_DONE : lss_pkg::LSS_ST_WAIT)
                 : lss_pkg::LSS_ST_WAIT;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state_q <= lss_pkg::LSS_ST_WAIT;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      pready_q <= access;
      pslverr_q <= access && !hit;
      // A refused write answers with zero data as well
      if (access && (!PWRITE || !hit)) begin
        prdata_q <= hit ? rd_word : 32'h0;
      end
    end
  end

  // Inputs are synchronous to CLOCK; one stage keeps reads and flags coherent
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      remote_lock_q <= 1'b0;
      backlink_q <= lss_pkg::RST_BACKLINK;  // [R8]
      pll_q <= lss_pkg::RST_PLL_LOCK;  // [R5]
      pins_q <= 4'h0;
    end else begin
      remote_lock_q <= LINK_IN.remote_lock;  // [R1]
      backlink_q <= LINK_IN.backlink_present;  // [R8]
      pll_q <= LINK_IN.pll_locked;  // [R5]
      pins_q <= PIN_LEVELS;  // [R9]
    end
  end

  assign link_change = LINK_IN.backlink_present ^ backlink_q;  // [R2]
  assign pll_lost = !LINK_IN.pll_locked;
  // Self-test errors are kept apart from the live check path
  assign check_ev = LINK_IN.backlink_err && LINK_IN.backlink_present
                  && !LINK_IN.selftest_mode;  // [R6]
  assign selftest_ev = LINK_IN.backlink_err && LINK_IN.selftest_mode;  // [R4]

  assign link_lost_d = link_change | (link_lost_q & ~err_clear_rd & ~pll_lost);  // [R3] [R17]
  assign check_err_d = check_ev | (check_err_q & ~err_clear_rd);  // [R7] [R17]
  assign selftest_err_d = selftest_ev | (selftest_err_q & ~err_clear_rd);  // [R4] [R17]

  // Clearing read restarts the tallies; an error in that cycle counts as one
  assign selftest_cnt_d = err_clear_rd ? {7'h0, selftest_ev}
                        : ((selftest_ev && selftest_cnt_q != 8'hff)
                           ? selftest_cnt_q + 8'h01 : selftest_cnt_q);  // [R10] [R18]
  assign check_cnt_d = err_clear_rd ? {15'h0, check_ev}
                     : ((check_ev && check_cnt_q != 16'hffff)
                        ? check_cnt_q + 16'h0001 : check_cnt_q);  // [R11] [R18]

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      link_lost_q <= 1'b0;
      check_err_q <= 1'b0;
      selftest_err_q <= 1'b0;
      selftest_cnt_q <= 8'h0;
      check_cnt_q <= 16'h0;
    end else begin
      link_lost_q <= link_lost_d;
      check_err_q <= check_err_d;
      selftest_err_q <= selftest_err_d;
      selftest_cnt_q <= selftest_cnt_d;
      check_cnt_q <= check_cnt_d;
    end
  end

  // One monitor per sensed quantity; only pin 0 exposes its extremes
  for (genvar c = 0; c < 3; c++) begin : g_chan
    lss_alarm_chan u_chan (
      .clk(CLOCK),
      .srst(SRST),
      .sense(SENSE[c]),
      .flag_clear(alarm_rd),  // [R12] [R13] [R14]
      .ext_clear(ext_rd),
      .over_flag(ch_over[c]),
      .under_flag(ch_under[c]),
      .peak(ch_peak[c]),
      .trough(ch_trough[c])
    );
    assign alarm_bits[2*c+1] = ch_over[c];  // [R12] [R13] [R14]
    assign alarm_bits[2*c] = ch_under[c];  // [R12] [R13] [R14]
    // Live level, not the sticky flag, so a status read really clears the source
    assign ch_live[c] = (SENSE[c].code > SENSE[c].hi_limit)
                      || (SENSE[c].code < SENSE[c].lo_limit);
  end

  always_comb begin
    general_word = 8'h0;
    general_word[lss_pkg::GS_REMOTE_LOCK] = remote_lock_q;  // [R1]
    general_word[lss_pkg::GS_LINK_LOST] = link_lost_q;  // [R2]
    general_word[lss_pkg::GS_SELFTEST_ERR] = selftest_err_q;  // [R4]
    general_word[lss_pkg::GS_PLL_LOCK] = pll_q;  // [R5]
    general_word[lss_pkg::GS_CHECK_ERR] = check_err_q;  // [R6]
    general_word[lss_pkg::GS_BACKLINK] = backlink_q;  // [R8]
  end

  // Reserved and upper bits read as zero
  always_comb begin
    case (idx)
      lss_pkg::IDX_GENERAL: rd_word = {24'h0, general_word};
      lss_pkg::IDX_PINS: rd_word = {28'h0, pins_q};  // [R9] [R18]
      lss_pkg::IDX_SELFTEST_CNT: rd_word = {24'h0, selftest_cnt_q};  // [R10]
      lss_pkg::IDX_CHECK_LO: rd_word = {24'h0, check_cnt_q[7:0]};  // [R11]
      lss_pkg::IDX_CHECK_HI: rd_word = {24'h0, check_cnt_q[15:8]};  // [R11]
      lss_pkg::IDX_ALARM: rd_word = {26'h0, alarm_bits};  // [R18]
      lss_pkg::IDX_PIN0_EXT: rd_word = {25'h0, ch_peak[lss_pkg::CH_PIN0], 1'b0,
                                        ch_trough[lss_pkg::CH_PIN0]};  // [R15] [R16]
      lss_pkg::IDX_IRQ_STATUS: rd_word = {28'h0, irq_st_q};
      lss_pkg::IDX_IRQ_MASK: rd_word = {28'h0, irq_mask_q};
      default: rd_word = 32'h0;
    endcase
  end

  // Interrupt sources mirror the sticky flags' set events
  always_comb begin
    irq_ev = 4'h0;
    irq_ev[lss_pkg::IRQ_LINK] = link_change;
    irq_ev[lss_pkg::IRQ_CHECK] = check_ev;
    irq_ev[lss_pkg::IRQ_SELFTEST] = selftest_ev;
    irq_ev[lss_pkg::IRQ_ALARM] = |ch_live;
  end

  assign irq_st_d = irq_ev | (irq_st_q & ~{4{irq_rd}});  // [R17]
  assign irq_mask_d = mask_wr ? PWDATA[3:0] : irq_mask_q;

  // IRQ uses next-state values so it rises together with the status bit
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_st_q <= 4'h0;
      irq_mask_q <= lss_pkg::RST_IRQ_MASK;
      irq_q <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= |(irq_st_d & irq_mask_d);
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ = irq_q;

endmodule : lss_status_regs

// file: hw/lss_pkg.sv
package lss_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_GENERAL = 8'h52;
  localparam logic [7:0] IDX_PINS = 8'h53;
  localparam logic [7:0] IDX_SELFTEST_CNT = 8'h54;
  localparam logic [7:0] IDX_CHECK_LO = 8'h55;
  localparam logic [7:0] IDX_CHECK_HI = 8'h56;
  localparam logic [7:0] IDX_ALARM = 8'h57;
  localparam logic [7:0] IDX_PIN0_EXT = 8'h58;
  localparam logic [7:0] IDX_ERR_CLEAR = 8'h70;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h71;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h72;

  // General status fields
  localparam int unsigned GS_REMOTE_LOCK = 6;
  localparam int unsigned GS_LINK_LOST = 4;
  localparam int unsigned GS_SELFTEST_ERR = 3;
  localparam int unsigned GS_PLL_LOCK = 2;
  localparam int unsigned GS_CHECK_ERR = 1;
  localparam int unsigned GS_BACKLINK = 0;
  localparam logic RST_PLL_LOCK = 1'b1;
  localparam logic RST_BACKLINK = 1'b1;

  localparam int unsigned PIN_W = 4;
  localparam int unsigned SELFTEST_CNT_W = 8;
  localparam int unsigned CHECK_CNT_W = 16;

  // Sensor channels and reading extremes
  localparam int unsigned SENSE_CH = 3;
  localparam int unsigned CH_PIN0 = 0;
  localparam int unsigned CH_PIN1 = 1;
  localparam int unsigned CH_TEMP = 2;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned EXT_MAX_LSB = 4;
  localparam int unsigned EXT_MIN_LSB = 0;
  localparam logic [2:0] PEAK_IDLE = 3'h0;
  localparam logic [2:0] TROUGH_IDLE = 3'h7;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_LINK = 0;
  localparam int unsigned IRQ_CHECK = 1;
  localparam int unsigned IRQ_SELFTEST = 2;
  localparam int unsigned IRQ_ALARM = 3;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  typedef struct packed {
    logic remote_lock;
    logic backlink_present;
    logic backlink_err;
    logic selftest_mode;
    logic pll_locked;
  } lss_link_t;

  typedef struct packed {
    logic [2:0] code;
    logic [2:0] hi_limit;
    logic [2:0] lo_limit;
  } lss_sense_t;

  typedef enum logic [1:0] {
    LSS_ST_WAIT = 2'b01,
    LSS_ST_DONE = 2'b10
  } lss_state_t;

endpackage : lss_pkg

// file: hw/lss_alarm_chan.sv
`timescale 1ns/1ps
module lss_alarm_chan (
  input wire logic clk,
  input wire logic srst,
  input wire lss_pkg::lss_sense_t sense,
  input wire logic flag_clear,
  input wire logic ext_clear,
  output logic over_flag,
  output logic under_flag,
  output logic [2:0] peak,
  output logic [2:0] trough
);

  logic over_now;
  logic under_now;
  logic over_q;
  logic over_d;
  logic under_q;
  logic under_d;
  logic [2:0] peak_q;
  logic [2:0] peak_d;
  logic [2:0] trough_q;
  logic [2:0] trough_d;

  assign over_now = sense.code > sense.hi_limit;
  assign under_now = sense.code < sense.lo_limit;

  // A new alarm in the clearing cycle survives the read
  assign over_d = over_now | (over_q & ~flag_clear);  // [R17]
  assign under_d = under_now | (under_q & ~flag_clear);  // [R17]

  // On a read that meets an alarm the fresh reading restarts the extreme
  assign peak_d = over_now ? ((ext_clear || sense.code > peak_q) ? sense.code : peak_q)
                : (ext_clear ? lss_pkg::PEAK_IDLE : peak_q);  // [R15]
  assign trough_d = under_now ? ((ext_clear || sense.code < trough_q) ? sense.code : trough_q)
                  : (ext_clear ? lss_pkg::TROUGH_IDLE : trough_q);  // [R16]

  always_ff @(posedge clk) begin
    if (srst) begin
      over_q <= 1'b0;
      under_q <= 1'b0;
      peak_q <= lss_pkg::PEAK_IDLE;
      trough_q <= lss_pkg::TROUGH_IDLE;
    end else begin
      over_q <= over_d;
      under_q <= under_d;
      peak_q <= peak_d;
      trough_q <= trough_d;
    end
  end

  assign over_flag = over_q;
  assign under_flag = under_q;
  assign peak = peak_q;
  assign trough = trough_q;

endmodule : lss_alarm_chan

// file: test/lss_status_regs_properties.sv
`timescale 1ns/1ps
module lss_status_regs_properties #(
  parameter int ADDR_W = 10
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire lss_pkg::lss_link_t LINK_IN,
  input wire logic [3:0] PIN_LEVELS,
  input wire lss_pkg::lss_sense_t [2:0] SENSE,
  input wire logic IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Status flops hold the inputs sampled one edge before the taking edge
  sequence taken(logic [7:0] idx);
    PSEL && PENABLE && !PWRITE && !PREADY && PADDR == {idx, 2'b00};
  endsequence
  a_ready_next: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_err_no_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error answer malformed");
  a_remote_backlink: assert property (taken(8'h52) |=>
    PRDATA[6] == $past(LINK_IN.remote_lock, 2) && PRDATA[0] == $past(LINK_IN.backlink_present, 2))
    else $error("lock or link bit wrong");
  a_pll_bit: assert property (taken(8'h52) |=> PRDATA[2] == $past(LINK_IN.pll_locked, 2))
    else $error("pll bit wrong");
  a_lost_set: assert property (taken(8'h52)
    ##0 $past(LINK_IN.backlink_present) != $past(LINK_IN.backlink_present, 2) |=> PRDATA[4])
    else $error("link change not flagged");
  a_lost_pll_clear: assert property (taken(8'h52) ##0 (!$past(LINK_IN.pll_locked) &&
    $past(LINK_IN.backlink_present) == $past(LINK_IN.backlink_present, 2)) |=> !PRDATA[4])
    else $error("lost flag kept without pll lock");
  a_gen_reserved: assert property (taken(8'h52) |=> PRDATA[31:8] == 24'h0 &&
    !PRDATA[7] && !PRDATA[5]) else $error("reserved bits set");
  a_pins_reserved: assert property (taken(8'h53) |=> PRDATA[31:4] == 28'h0)
    else $error("pin reserved bits set");
  a_pin0_over: assert property (taken(8'h57)
    ##0 $past(SENSE[0].code > SENSE[0].hi_limit) |=> PRDATA[1])
    else $error("over alarm missing");
endmodule : lss_status_regs_properties

bind lss_status_regs lss_status_regs_properties #(.ADDR_W(ADDR_W)) u_props (
  .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .LINK_IN(LINK_IN), .PIN_LEVELS(PIN_LEVELS), .SENSE(SENSE), .IRQ(IRQ)
);

// file: test/lss_status_regs_tb.sv
`timescale 1ns/1ps
module lss_status_regs_tb;
  localparam logic [8:0] NORM = 9'h0e9;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [3:0] pins = 4'ha;
  lss_pkg::lss_link_t link = 5'h09;
  lss_pkg::lss_sense_t [2:0] sense = {3{NORM}};
  logic [31:0] rdv;
  logic errv;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  lss_status_regs u_dut (.CLOCK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .LINK_IN(link), .PIN_LEVELS(pins), .SENSE(sense), .IRQ(irq));
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task apb(logic wr, logic [7:0] idx, logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(logic [7:0] idx, logic [7:0] exp, string name);
    apb(1'b0, idx, 32'h0);
    check(name, rdv, {24'h0, exp});
    check("slverr", {31'h0, errv}, 32'h0);
  endtask : rd
  task pulse(int n);
    @(posedge clk);
    link.backlink_err <= 1'b1;
    repeat (n) @(posedge clk);
    link.backlink_err <= 1'b0;
  endtask : pulse
  task t_reset;
    rd(8'h52, 8'h05, "general");
    rd(8'h54, 8'h00, "selftest");
    rd(8'h55, 8'h00, "chk_lo");
    rd(8'h56, 8'h00, "chk_hi");
    rd(8'h58, 8'h07, "pin0_ext");
    rd(8'h53, 8'h0a, "pins");
    pins <= 4'h5;
    rd(8'h53, 8'h05, "pins");
  endtask : t_reset
  task t_link;
    link.remote_lock <= 1'b1;
    rd(8'h52, 8'h45, "general");
    link.backlink_present <= 1'b0;
    rd(8'h52, 8'h54, "general");
    rd(8'h70, 8'h00, "errclr");
    rd(8'h52, 8'h44, "general");
    link.backlink_present <= 1'b1;
    @(posedge clk);
    link.pll_locked <= 1'b0;
    rd(8'h52, 8'h41, "general");
    link.pll_locked <= 1'b1;
    link.remote_lock <= 1'b0;
  endtask : t_link
  task t_errors;
    pulse(3);
    rd(8'h52, 8'h07, "general");
    rd(8'h52, 8'h07, "general");
    rd(8'h55, 8'h03, "chk_lo");
    rd(8'h56, 8'h00, "chk_hi");
    link.selftest_mode <= 1'b1;
    pulse(300);
    rd(8'h54, 8'hff, "selftest");
    rd(8'h52, 8'h0f, "general");
    link.selftest_mode <= 1'b0;
    link.backlink_present <= 1'b0;
    pulse(2);
    rd(8'h55, 8'h03, "chk_lo");
    link.backlink_present <= 1'b1;
    rd(8'h70, 8'h00, "errclr");
    rd(8'h52, 8'h05, "general");
    rd(8'h55, 8'h00, "chk_lo");
    rd(8'h54, 8'h00, "selftest");
    pulse(257);
    rd(8'h55, 8'h01, "chk_lo");
    rd(8'h56, 8'h01, "chk_hi");
    // Errors keep coming while the clearing read is taken
    link.backlink_err <= 1'b1;
    rd(8'h70, 8'h00, "errclr");
    link.backlink_err <= 1'b0;
    rd(8'h52, 8'h07, "general");
    rd(8'h55, 8'h02, "chk_lo");
  endtask : t_errors
  task t_sensor;
    sense <= {9'h029, 9'h1e9, 9'h1a1};
    repeat (2) @(posedge clk);
    sense <= {3{NORM}};
    rd(8'h57, 8'h1a, "alarm");
    rd(8'h57, 8'h00, "alarm");
    rd(8'h58, 8'h67, "pin0_ext");
    rd(8'h58, 8'h07, "pin0_ext");
    sense[0] <= 9'h06b;
    @(posedge clk);
    sense[0] <= NORM;
    rd(8'h58, 8'h01, "pin0_ext");
    rd(8'h57, 8'h01, "alarm");
  endtask : t_sensor
  task t_irq_bus;
    rd(8'h71, 8'h0f, "irq_status");
    check("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, 8'h72, 32'h8);
    rd(8'h72, 8'h08, "irq_mask");
    sense[2] <= 9'h1a9;
    repeat (2) @(posedge clk);
    sense[2] <= NORM;
    @(posedge clk);
    check("irq", {31'h0, irq}, 32'h1);
    rd(8'h71, 8'h08, "irq_status");
    check("irq", {31'h0, irq}, 32'h0);
    rd(8'h57, 8'h20, "alarm");
    apb(1'b1, 8'h60, 32'h0);
    check("unmapped_wr_err", {31'h0, errv}, 32'h1);
    check("err_data", rdv, 32'h0);
    apb(1'b0, 8'h60, 32'h0);
    check("unmapped_err", {31'h0, errv}, 32'h1);
    apb(1'b1, 8'h53, 32'hff);
    check("ro_write_err", {31'h0, errv}, 32'h0);
    rd(8'h53, 8'h05, "pins");
  endtask : t_irq_bus
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // Ceiling is about four times the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_link();
    t_errors();
    t_sensor();
    t_irq_bus();
    report_and_stop();
  end
endmodule : lss_status_regs_tb
